/* rtl/eepc_program_erase_ctrl.sv */
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Array decodes at page nibble E00 to FFF.
// - Single-chip and bootstrap force page F.
// - Fresh part reads page nibble as zero.
// - Setup bits 3 and 1 read one.
// - Watchdog resets only when disable bit clear.
// - Map enable forced by mode out of reset.
// - Map enable zero removes the array.
// - Protected blocks are never programmed or erased.
// - Row erase clears aligned sixteen-byte row.
// - Latched array write enables whole-array bulk erase.
// - Control bits: voltage, latch, erase, row, byte.
// - Bulk erase of setup word erases everything.
// - Setup word writable any mode unless protected.
// - New setup word acts after next reset.
// - Setup word programs like an array byte.
// - Byte and row bits choose erase extent.
// - Latch bit reconfigures array buses for programming.
module eepc_program_erase_ctrl
  import eepc_pkg::*;
#(
  parameter logic [3:0] REG_PAGE = 4'h1
) (
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire eepc_apb_req_t apbReq,
  output var  eepc_apb_rsp_t apbRsp,
  input  wire logic [1:0]    opModePins,
  input  wire logic          watchdogTimeout,
  output var  logic          watchdogResetReq,
  output var  logic          arrayMapPresent,
  output var  logic [3:0]    arrayMapBase,
  output var  logic          highVoltageOn
);

  // All state of the controller in one record.
  typedef struct packed {
    eepc_boot_t    boot;            // Reset load sequence.
    logic [1:0]    modeSync1;       // First synchroniser stage.
    logic [1:0]    modeSync2;       // Second synchroniser stage.
    logic [1:0]    mode;            // Mode captured after reset.
    logic [6:0]    bpAge;           // Cycles since reset, saturating.
    logic [3:0]    activePage;      // Page in force since reset.
    logic          activeMapEnable; // Map enable in force.
    logic          activeWdDisable; // Watchdog disable in force.
    logic [4:0]    pcReg;           // Program control register.
    logic [4:0]    bpReg;           // Block protect register.
    logic          latchValid;      // A target has been latched.
    logic [9:0]    latchAddr;       // Latched store index.
    logic [7:0]    latchData;       // Latched program data.
    eepc_op_t      op;              // High-voltage operation state.
    logic [9:0]    sweep;           // Erase sweep position.
    logic [9:0]    sweepEnd;        // Last index of the sweep.
    logic          memRdPending;    // Array read awaiting store data.
    eepc_apb_rsp_t rsp;             // Registered bus answer.
    logic          wdReq;           // Registered watchdog reset request.
    logic          hvOut;           // Registered high-voltage indication.
    logic          mapPresent;      // Registered array presence.
    logic [3:0]    mapBase;         // Registered array page.
  } eepc_state_t;

  localparam eepc_state_t STATE_RESET = '{
    boot: BOOT_SYNC, op: OP_IDLE, pcReg: PC_RESET, bpReg: BP_RESET, default: '0
  };

  eepc_state_t s;          // Current state.
  eepc_state_t next_s;     // Next state.
  logic        memEn;      // Store access strobe.
  logic        memWe;      // Store write select.
  logic [9:0]  memAddr;    // Store index.
  logic [7:0]  memWdata;   // Store write data.
  logic [7:0]  memRdata;   // Registered store read data.

  // Map a bus address onto a target; registers outrank the array.
  function automatic eepc_hit_t decodeHit(input logic [APB_ADDR_W-1:0] addr,
                                          input logic present, input logic [3:0] page);
    logic [15:0] cpu;
    cpu = addr[17:2];
    decodeHit = HIT_NONE;
    if (addr[1:0] != 2'h0) begin
      decodeHit = HIT_NONE;
    end else if (cpu[15:12] == REG_PAGE && cpu[11:0] == OFS_BLOCK_PROTECT) begin
      decodeHit = HIT_BP;
    end else if (cpu[15:12] == REG_PAGE && cpu[11:0] == OFS_PROGRAM_CONTROL) begin
      decodeHit = HIT_PC;
    end else if (cpu[15:12] == REG_PAGE && cpu[11:0] == OFS_SETUP_WORD) begin
      decodeHit = HIT_SW;
    end else if (present && cpu[15:12] == page && cpu[11:9] == ARRAY_PAGE_TOP) begin
      decodeHit = HIT_ARRAY;
    end
  endfunction

  // True when the block holding a store index is write protected.
  function automatic logic isProtected(input logic [9:0] idx, input logic [4:0] bp);
    if (idx[9]) begin
      isProtected = bp[BP_SETUP];
    end else if (idx[8:0] < BLK1_START) begin
      isProtected = bp[0];
    end else if (idx[8:0] < BLK2_START) begin
      isProtected = bp[1];
    end else if (idx[8:0] < BLK3_START) begin
      isProtected = bp[2];
    end else begin
      isProtected = bp[3];
    end
  endfunction

  // Setup word as software sees it, fixed bits reading one.
  function automatic logic [7:0] setupView(input eepc_state_t st);
    setupView = SW_FIXED_ONES;
    setupView[SW_PAGE_LSB +: 4] = st.activePage;
    setupView[SW_WD_DISABLE] = st.activeWdDisable;
    setupView[SW_MAP_ENABLE] = st.activeMapEnable;
  endfunction

  // The nonvolatile cells: 512 array bytes followed by the setup word.
  eepc_nv_store #(
    .DATA_W    (8),
    .DEPTH     (STORE_DEPTH),
    .ADDR_W    (STORE_ADDR_W),
    .FILL      (ERASED_BYTE),
    .LAST_FILL (SW_FRESH_VALUE)
  ) u_store (
    .clk   (ref_clk),
    .en    (memEn),
    .we    (memWe),
    .addr  (memAddr),
    .wdata (memWdata),
    .rdata (memRdata)
  );

  // Next-state logic for boot load, high-voltage engine and bus slave.
  always_comb begin
    eepc_hit_t  hit;
    logic       hvReq;
    logic       stoBusy;
    logic       access;
    logic [7:0] rdByte;
    logic [4:0] wr5;
    next_s = s;
    hit = decodeHit(apbReq.paddr, s.mapPresent, s.mapBase);
    hvReq = 1'b0;
    stoBusy = 1'b0;
    access = apbReq.psel && apbReq.penable;
    rdByte = 8'h00;
    wr5 = apbReq.pwdata[4:0];
    memEn = 1'b0;
    memWe = 1'b0;
    memAddr = 10'h000;
    memWdata = 8'h00;
    // Answer lines stand for exactly one cycle.
    next_s.rsp.pready = 1'b0;
    next_s.rsp.pslverr = 1'b0;
    // Mode pins come from outside; two flops before use.
    next_s.modeSync1 = opModePins;
    next_s.modeSync2 = s.modeSync1;
    if (s.bpAge != BP_CLEAR_WINDOW) begin
      next_s.bpAge = s.bpAge + 7'h01;
    end
    // Voltage reaches the cells only while every enabling bit is set.
    hvReq = s.pcReg[PC_VOLTAGE] && s.pcReg[PC_LATCH] && s.latchValid;
    case (s.boot)
      BOOT_SYNC: begin
        next_s.boot = BOOT_WAIT;
      end
      BOOT_WAIT: begin
        next_s.boot = BOOT_CAPTURE;
      end
      BOOT_CAPTURE: begin
        // Mode straps are caught only once the synchroniser has filled.
        next_s.mode = s.modeSync2;
        next_s.boot = BOOT_LOAD;
      end
      BOOT_LOAD: begin
        // Fetch the stored setup word; it governs until the next reset.
        memEn = 1'b1;
        memAddr = SETUP_INDEX;
        next_s.boot = BOOT_TAKE;
      end
      BOOT_TAKE: begin
        next_s.activePage = memRdata[SW_PAGE_LSB +: 4];
        next_s.activeWdDisable = memRdata[SW_WD_DISABLE];
        if (s.mode == MODE_SINGLE || s.mode == MODE_BOOTSTRAP) begin
          next_s.activeMapEnable = 1'b1;
          next_s.mapBase = FORCED_PAGE;
        end else if (s.mode == MODE_TEST) begin
          next_s.activeMapEnable = 1'b0;
          next_s.mapBase = memRdata[SW_PAGE_LSB +: 4];
        end else begin
          next_s.activeMapEnable = memRdata[SW_MAP_ENABLE];
          next_s.mapBase = memRdata[SW_PAGE_LSB +: 4];
        end
        next_s.boot = BOOT_RUN;
      end
      BOOT_RUN: begin
        // High-voltage engine owns the store port while it writes.
        case (s.op)
          OP_IDLE: begin
            if (hvReq && !s.pcReg[PC_ERASE]) begin
              // Program the latched byte once, if its block allows.
              if (!isProtected(s.latchAddr, s.bpReg)) begin
                memEn = 1'b1;
                memWe = 1'b1;
                memAddr = s.latchAddr;
                memWdata = s.latchData;
                stoBusy = 1'b1;
              end
              next_s.op = OP_HOLD;
            end else if (hvReq) begin
              // Erase extent follows the byte and row bits.
              if (s.pcReg[PC_BYTE]) begin
                next_s.sweep = s.latchAddr;
                next_s.sweepEnd = s.latchAddr;
              end else if (s.pcReg[PC_ROW] && !s.latchAddr[9]) begin
                next_s.sweep = {s.latchAddr[9:4], 4'h0};
                next_s.sweepEnd = {s.latchAddr[9:4], 4'hf};
              end else if (s.pcReg[PC_ROW]) begin
                next_s.sweep = s.latchAddr;
                next_s.sweepEnd = s.latchAddr;
              end else begin
                next_s.sweep = 10'h000;
                next_s.sweepEnd = s.latchAddr[9] ? SETUP_INDEX : ARRAY_LAST;
              end
              next_s.op = OP_SWEEP;
            end
          end
          OP_SWEEP: begin
            if (!hvReq) begin
              // Dropping the voltage bit abandons the rest of the sweep.
              next_s.op = OP_IDLE;
            end else begin
              if (!isProtected(s.sweep, s.bpReg)) begin
                memEn = 1'b1;
                memWe = 1'b1;
                memAddr = s.sweep;
                memWdata = ERASED_BYTE;
                stoBusy = 1'b1;
              end
              if (s.sweep == s.sweepEnd) begin
                next_s.op = OP_HOLD;
              end else begin
                next_s.sweep = s.sweep + 10'h001;
              end
            end
          end
          OP_HOLD: begin
            if (!hvReq) begin
              next_s.op = OP_IDLE;
            end
          end
          default: begin
            next_s.op = OP_IDLE;
          end
        endcase
        // Access phase: decide the answer once, then commit at pready.
        if (access && !s.rsp.pready) begin
          if (s.memRdPending) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.prdata = {24'h000000, memRdata};
            next_s.memRdPending = 1'b0;
          end else if (hit == HIT_ARRAY && !apbReq.pwrite && !s.pcReg[PC_LATCH]) begin
            // Normal array read goes through the registered store port.
            if (!stoBusy) begin
              memEn = 1'b1;
              memAddr = {1'b0, apbReq.paddr[10:2]};
              next_s.memRdPending = 1'b1;
            end
          end else begin
            case (hit)
              HIT_BP:    rdByte = {3'h0, s.bpReg};
              HIT_PC:    rdByte = {3'h0, s.pcReg};
              HIT_SW:    rdByte = setupView(s);
              HIT_ARRAY: rdByte = s.latchData;
              default:   rdByte = 8'h00;
            endcase
            next_s.rsp.pready = 1'b1;
            next_s.rsp.pslverr = (hit == HIT_NONE);
            next_s.rsp.prdata = {24'h000000, rdByte};
          end
        end
        // Writes take effect at the edge where pready is seen high.
        if (access && s.rsp.pready && apbReq.pwrite && !s.rsp.pslverr) begin
          case (hit)
            HIT_BP: begin
              // Clearing protection is allowed early after reset or in special modes.
              if (s.bpAge != BP_CLEAR_WINDOW || s.mode == MODE_TEST
                  || s.mode == MODE_BOOTSTRAP) begin
                next_s.bpReg = wr5;
              end else begin
                next_s.bpReg = s.bpReg | wr5;
              end
            end
            HIT_PC: begin
              next_s.pcReg = wr5;
              if (!wr5[PC_LATCH]) begin
                next_s.latchValid = 1'b0;
              end
            end
            HIT_SW: begin
              if (s.pcReg[PC_LATCH] && !s.pcReg[PC_VOLTAGE]) begin
                // The setup word is a target like any array byte.
                next_s.latchValid = 1'b1;
                next_s.latchAddr = SETUP_INDEX;
                next_s.latchData = apbReq.pwdata[7:0];
              end else if (!s.pcReg[PC_LATCH] && s.mode == MODE_TEST) begin
                // Test software may bring the array back into the map.
                next_s.activeMapEnable = apbReq.pwdata[SW_MAP_ENABLE];
              end
            end
            HIT_ARRAY: begin
              if (s.pcReg[PC_LATCH] && !s.pcReg[PC_VOLTAGE]) begin
                next_s.latchValid = 1'b1;
                next_s.latchAddr = {1'b0, apbReq.paddr[10:2]};
                next_s.latchData = apbReq.pwdata[7:0];
              end
            end
            default: begin
              next_s.latchValid = s.latchValid;
            end
          endcase
        end
      end
      default: begin
        next_s.boot = BOOT_SYNC;
      end
    endcase
    // Registered copies of everything that leaves the block.
    next_s.wdReq = watchdogTimeout && !s.activeWdDisable;
    next_s.hvOut = hvReq && s.boot == BOOT_RUN && s.op != OP_IDLE;
    next_s.mapPresent = next_s.activeMapEnable;
  end

  // One register stage for the whole state record.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs are fields of the registered state.
  assign apbRsp = s.rsp;
  assign watchdogResetReq = s.wdReq;
  assign arrayMapPresent = s.mapPresent;
  assign arrayMapBase = s.mapBase;
  assign highVoltageOn = s.hvOut;

endmodule
`default_nettype wire

/* rtl/eepc_pkg.sv */
// Shared constants and carrier types for the nonvolatile array controller.
package eepc_pkg;

  // APB carries the CPU address space with one 32-bit word per CPU byte.
  localparam int unsigned APB_ADDR_W = 18;
  localparam int unsigned APB_DATA_W = 32;

  // CPU-side register offsets within the register page.
  localparam logic [11:0] OFS_BLOCK_PROTECT   = 12'h035;
  localparam logic [11:0] OFS_PROGRAM_CONTROL = 12'h03b;
  localparam logic [11:0] OFS_SETUP_WORD      = 12'h03f;

  // The array occupies the top 512 bytes of a 4 KB page.
  localparam logic [2:0] ARRAY_PAGE_TOP = 3'h7;
  localparam logic [3:0] FORCED_PAGE    = 4'hf;

  // Program control field positions.
  localparam int unsigned PC_VOLTAGE = 0;
  localparam int unsigned PC_LATCH   = 1;
  localparam int unsigned PC_ERASE   = 2;
  localparam int unsigned PC_ROW     = 3;
  localparam int unsigned PC_BYTE    = 4;
  localparam logic [4:0]  PC_RESET   = 5'h00;

  // Block protect fields; bit 4 guards the setup word.
  localparam int unsigned BP_SETUP = 4;
  localparam logic [4:0]  BP_RESET = 5'h1f;
  localparam logic [6:0]  BP_CLEAR_WINDOW = 7'h40;

  // Setup word fields.
  localparam int unsigned SW_MAP_ENABLE  = 0;
  localparam int unsigned SW_WD_DISABLE  = 2;
  localparam int unsigned SW_PAGE_LSB    = 4;
  localparam logic [7:0]  SW_FIXED_ONES  = 8'h0a;
  localparam logic [7:0]  SW_FRESH_VALUE = 8'h0a;

  // Storage geometry: 512 array bytes, then the setup word.
  localparam int unsigned STORE_DEPTH  = 513;
  localparam int unsigned STORE_ADDR_W = 10;
  localparam logic [9:0]  SETUP_INDEX  = 10'h200;
  localparam logic [9:0]  ARRAY_LAST   = 10'h1ff;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;

  // Protected block boundaries, as array offsets.
  localparam logic [8:0] BLK1_START = 9'h020;
  localparam logic [8:0] BLK2_START = 9'h060;
  localparam logic [8:0] BLK3_START = 9'h0e0;

  // Operating mode codes as presented on the mode pins.
  localparam logic [1:0] MODE_BOOTSTRAP = 2'h0;
  localparam logic [1:0] MODE_SINGLE    = 2'h1;
  localparam logic [1:0] MODE_TEST      = 2'h2;
  localparam logic [1:0] MODE_EXPANDED  = 2'h3;

  typedef enum logic [2:0] {
    BOOT_SYNC, BOOT_WAIT, BOOT_CAPTURE, BOOT_LOAD, BOOT_TAKE, BOOT_RUN
  } eepc_boot_t;

  typedef enum logic [1:0] {OP_IDLE, OP_SWEEP, OP_HOLD} eepc_op_t;

  typedef enum logic [2:0] {HIT_NONE, HIT_BP, HIT_PC, HIT_SW, HIT_ARRAY} eepc_hit_t;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
  } eepc_apb_req_t;

  typedef struct packed {
    logic [APB_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
  } eepc_apb_rsp_t;

endpackage

/* rtl/eepc_nv_store.sv */
`timescale 1ns/1ns
`default_nettype none
// Single-port nonvolatile cell store with registered read data.
module eepc_nv_store #(
  parameter int unsigned DATA_W    = 8,
  parameter int unsigned DEPTH     = 513,
  parameter int unsigned ADDR_W    = 10,
  parameter logic [7:0]  FILL      = 8'hff,
  parameter logic [7:0]  LAST_FILL = 8'h0a
) (
  input  wire logic              clk,
  input  wire logic              en,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output var  logic [DATA_W-1:0] rdata
);

  // Refuse a geometry the address cannot reach.
  if (DEPTH > (2 ** ADDR_W) || DATA_W != 8) begin : g_bad_geometry
    $error("Store geometry not supported.");
  end

  logic [DATA_W-1:0] cells [DEPTH];  // Cell contents; reset leaves them alone.

  // Factory contents: erased array, fresh setup word in the last cell.
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      cells[i] = (i == DEPTH - 1) ? LAST_FILL : FILL;
    end
  end

  // One access per clock; the read word is registered. A plain always is used
  // because the factory preload above fills the same cells from an initial block.
  always @(posedge clk) begin
    if (en && we) begin
      cells[addr] <= wdata;
    end
    if (en && !we) begin
      rdata <= cells[addr];
    end
  end

endmodule
`default_nettype wire

/* dv/eepc_pec_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checker for the program/erase controller.
module eepc_pec_assertions
  import eepc_pkg::*;
#(
  parameter logic [3:0] REG_PAGE = 4'h1
) (
  input wire logic          ref_clk,
  input wire logic          resetn,
  input wire eepc_apb_req_t apbReq,
  input wire eepc_apb_rsp_t apbRsp,
  input wire logic [1:0]    opModePins,
  input wire logic          watchdogTimeout,
  input wire logic          watchdogResetReq,
  input wire logic          arrayMapPresent,
  input wire logic [3:0]    arrayMapBase,
  input wire logic          highVoltageOn
);
  // Bus byte address of the program control register.
  localparam logic [17:0] PC_ADDR = {REG_PAGE, OFS_PROGRAM_CONTROL, 2'b00};
  logic       pcHit; // A write to program control commits this cycle.
  logic [1:0] pcLow; // Voltage and latch bits as last written.
  assign pcHit = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready
                 && (apbReq.paddr == PC_ADDR);
  // Mirrors the control bits so the voltage output can be tied to them.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pcLow <= 2'b00;
    end else if (pcHit) begin
      pcLow <= apbReq.pwdata[1:0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // The engine may lag the register by two cycles, never more.
  a_hv_gate: assert property (highVoltageOn |-> (pcLow == 2'b11)
    || ($past(pcLow) == 2'b11) || ($past(pcLow, 2) == 2'b11)) else $error("voltage without bits");
  a_wd_cause: assert property (watchdogResetReq |-> $past(watchdogTimeout))
    else $error("watchdog reset without timeout");
  a_forced_page: assert property (arrayMapPresent && (opModePins == MODE_SINGLE
    || opModePins == MODE_BOOTSTRAP) |-> arrayMapBase == FORCED_PAGE) else $error("page not forced");
  a_single_present: assert property (apbRsp.pready && opModePins == MODE_SINGLE
    |-> arrayMapPresent) else $error("array absent in single-chip mode");
  a_map_stable: assert property ($past(arrayMapPresent) && arrayMapPresent
    |-> $stable(arrayMapBase)) else $error("map base moved without reset");
  a_reg_latency: assert property (apbReq.psel && apbReq.penable && !$past(apbReq.penable)
    && apbReq.paddr == PC_ADDR |-> ##1 apbRsp.pready) else $error("control answer late");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error without ready");
endmodule
bind eepc_program_erase_ctrl eepc_pec_assertions #(.REG_PAGE(REG_PAGE)) eepc_pec_assertions_inst (
  .ref_clk(ref_clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
  .opModePins(opModePins), .watchdogTimeout(watchdogTimeout),
  .watchdogResetReq(watchdogResetReq), .arrayMapPresent(arrayMapPresent),
  .arrayMapBase(arrayMapBase), .highVoltageOn(highVoltageOn));
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Compares one value and counts it; a mismatch is reported at once.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top
  import eepc_pkg::*;
;
  logic          ref_clk = 1'b0;        // Bench clock, 50 ns period.
  logic          resetn = 1'b0;         // Active-low reset.
  eepc_apb_req_t req = '0;              // Bus request driven by the bench.
  eepc_apb_rsp_t rsp;                   // Bus answer.
  logic [1:0]    modePins = MODE_SINGLE; // Mode straps.
  logic          wdTimeout = 1'b0;      // Watchdog time-out pulse.
  logic          wdReset;               // Watchdog reset request.
  logic          mapPresent;            // Array present in the map.
  logic [3:0]    mapBase;               // Page nibble of the array.
  logic          hvOn;                  // High voltage applied.
  logic [7:0]    q;                     // Last read byte.
  logic          err;                   // Last error response.
  int            error_cnt = 0;         // Mismatches seen.
  int            n_compared = 0;        // Comparisons made.
  // CPU addresses of the three registers.
  localparam logic [15:0] BP = {4'h1, OFS_BLOCK_PROTECT};
  localparam logic [15:0] PC = {4'h1, OFS_PROGRAM_CONTROL};
  localparam logic [15:0] SW = {4'h1, OFS_SETUP_WORD};
  always #25 ref_clk = ~ref_clk;
  eepc_program_erase_ctrl #(.REG_PAGE(4'h1)) eepc_program_erase_ctrl_inst (
    .ref_clk(ref_clk), .resetn(resetn), .apbReq(req), .apbRsp(rsp),
    .opModePins(modePins), .watchdogTimeout(wdTimeout), .watchdogResetReq(wdReset),
    .arrayMapPresent(mapPresent), .arrayMapBase(mapBase), .highVoltageOn(hvOn));
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; it starts a cycle late so no signal is assigned twice per step.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, {a, 2'b00}, {24'h0, d}};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 2000);
    q = rsp.prdata[7:0];
    err = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask
  // Reads a byte and compares it.
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  // Full software sequence for one program or erase operation.
  task automatic op(input logic [7:0] m, input logic [15:0] a, input logic [7:0] d,
                    input int wt, input logic chkHv);
    xfer(1'b1, PC, m);
    xfer(1'b1, a, d);
    xfer(1'b1, PC, m | 8'h01);
    repeat (wt) @(posedge ref_clk);
    if (chkHv) `CHK(hvOn, 1'b1)
    xfer(1'b1, PC, m);
    repeat (3) @(posedge ref_clk);
    `CHK(hvOn, 1'b0)
    xfer(1'b1, PC, 8'h00);
  endtask
  // Pulses the time-out and checks the reset request one cycle later.
  task automatic pulse_wd(input logic e);
    @(posedge ref_clk);
    wdTimeout <= 1'b1;
    @(posedge ref_clk);
    wdTimeout <= 1'b0;
    @(posedge ref_clk);
    `CHK(wdReset, e)
  endtask
  // Resets with the given straps and waits out the boot sequence.
  task automatic boot(input logic [1:0] m);
    resetn <= 1'b0;
    modePins <= m;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  // Main sequence: single-chip work, then expanded and test mode restarts.
  initial begin
    boot(MODE_SINGLE);
    xfer(1'b1, BP, 8'h00);
    `CHK(mapPresent, 1'b1)
    `CHK(mapBase, FORCED_PAGE)
    xfer(1'b0, SW, 8'h00);
    `CHK(q[7:4], 4'h0)
    `CHK({q[3], q[1]}, 2'b11)
    pulse_wd(1'b1);
    op(8'h02, 16'hfe05, 8'h33, 5, 1'b1);
    op(8'h02, 16'hfe11, 8'h55, 5, 1'b1);
    op(8'h02, 16'hfe10, 8'h44, 5, 1'b1);
    op(8'h02, 16'hfe40, 8'h66, 5, 1'b1);
    rdchk(16'hfe05, 8'h33);
    op(8'h0e, 16'hfe0a, 8'h00, 40, 1'b1);
    rdchk(16'hfe05, 8'hff);
    rdchk(16'hfe11, 8'h55);
    op(8'h16, 16'hfe10, 8'h00, 8, 1'b1);
    rdchk(16'hfe10, 8'hff);
    rdchk(16'hfe11, 8'h55);
    xfer(1'b1, BP, 8'h01);
    op(8'h02, 16'hfe02, 8'h12, 5, 1'b0);
    rdchk(16'hfe02, 8'hff);
    op(8'h06, 16'hfe45, 8'h00, 600, 1'b1);
    rdchk(16'hfe40, 8'hff);
    rdchk(16'hfe11, 8'h55);
    xfer(1'b0, 16'h2000, 8'h00);
    `CHK(err, 1'b1)
    op(8'h02, SW, 8'h35, 5, 1'b1);
    xfer(1'b0, SW, 8'h00);
    `CHK(q[7:4], 4'h0)
    `CHK(mapBase, FORCED_PAGE)
    boot(MODE_EXPANDED);
    `CHK(mapBase, 4'h3)
    `CHK(mapPresent, 1'b1)
    rdchk(SW, 8'h3f);
    pulse_wd(1'b0);
    rdchk(16'h3e11, 8'h55);
    boot(MODE_TEST);
    `CHK(mapPresent, 1'b0)
    // With the array out of the map its page must answer as unmapped.
    xfer(1'b0, 16'h3e11, 8'h00);
    `CHK(err, 1'b1)
    // Test mode may lift protection; a bulk erase aimed at the setup word takes everything.
    xfer(1'b1, BP, 8'h00);
    op(8'h06, SW, 8'h00, 600, 1'b1);
    boot(MODE_EXPANDED);
    `CHK(mapBase, 4'hf)
    rdchk(SW, 8'hff);
    rdchk(16'hfe11, 8'hff);
    complete_run();
  end
endmodule
`default_nettype wire
